// File: inc/tbnsc_pkg.sv
// Shared constants, types and helpers
package tbnsc_pkg;
  typedef enum logic [1:0] {MODE_PROGRAM, MODE_MONITOR, MODE_RUN} tbnsc_mode_t;
  typedef enum logic [1:0] {
    ATT_NONE, ATT_HOST_CPU, ATT_LINK_UNIT, ATT_PERIPH
  } tbnsc_attach_t;
  typedef enum logic [1:0] {
    BOOT_SYNC, BOOT_LOAD, BOOT_READY
  } tbnsc_boot_t;

  // Switch pin positions (pin n sits at index n-1)
  localparam logic [2:0] SW1_STARTUP_MON = 3'h4;
  localparam logic [2:0] SW1_PARAM_INIT = 3'h6;
  localparam logic [2:0] SW1_POLLED = 3'h7;
  localparam logic [2:0] SW2_PARAM_INIT = 3'h2;
  localparam logic [2:0] SW2_POLLED = 3'h3;

  // Network parameter word layout
  localparam int CYC_LSB = 0;
  localparam int FRM_LSB = 8;
  localparam int MAXN_LSB = 16;
  localparam int POLL_LSB = 24;
  localparam logic [7:0] CYC_AUTO = 8'h00;
  localparam logic [7:0] CYC_MIN = 8'h05;
  localparam logic [7:0] FRM_DEF = 8'h0A;
  localparam logic [7:0] FRM_MIN = 8'h05;
  localparam logic [5:0] MAXN_DEF = 6'h3E;
  localparam logic [5:0] MAXN_MIN = 6'h02;
  localparam logic [5:0] MAXN_MAX = 6'h3E;
  localparam logic [5:0] POLL_DEF = 6'h04;
  localparam logic [5:0] POLL_MIN = 6'h01;
  localparam logic [5:0] POLL_MAX = 6'h3E;
  localparam logic [31:0] PARAM_DEF = {2'h0, POLL_DEF, 2'h0, MAXN_DEF,
                                       FRM_DEF, CYC_AUTO};
  localparam logic [31:0] PARAM_MASK = 32'h3F3FFFFF;
  localparam logic [6:0] NODE_MIN = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h3E;
  localparam logic [5:0] NODE_FIRST = 6'h01;

  // Event budget: 10 frames give 4 events, 3 frames per further event
  localparam logic [8:0] EVT_FRAMES_EACH = 9'h003;
  localparam logic [8:0] EVT_ROUND = 9'h002;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYCLE_UNIT_NS = 1000000;
  localparam int CYCLE_UNIT_TICKS = CYCLE_UNIT_NS / CLK_PERIOD_NS;
  localparam int NVM_WRITE_NS = 5000;
  localparam int NVM_WR_CYCLES = (NVM_WRITE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_WAIT = 2'h2;
  localparam logic [3:0] NVM_TAG = 4'hA; // Arbitrary validity marker

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PARAM = 8'h08;
  localparam logic [7:0] REG_NODE_WORD = 8'h0C;
  localparam logic [7:0] REG_CONFLICT = 8'h10;
  localparam logic [7:0] REG_POLL = 8'h14;
  localparam int CTRL_LINK_RUN = 0;
  localparam int CONFLICT_BIT = 0;
  localparam int NW_COMM_ERR = 14;
  localparam int NW_NVM_ERR = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  function automatic logic param_ok(input logic [31:0] w);
    logic [7:0] cyc;
    logic [7:0] frm;
    logic [5:0] mx;
    logic [5:0] pl;
    cyc = w[CYC_LSB +: 8];
    frm = w[FRM_LSB +: 8];
    mx = w[MAXN_LSB +: 6];
    pl = w[POLL_LSB +: 6];
    return (cyc == CYC_AUTO || cyc >= CYC_MIN) && frm >= FRM_MIN &&
           mx >= MAXN_MIN && mx <= MAXN_MAX && pl >= POLL_MIN &&
           pl <= POLL_MAX;
  endfunction : param_ok

  function automatic logic [7:0] event_cap(input logic [7:0] frames);
    logic [8:0] t;
    t = ({1'b0, frames} + EVT_ROUND) / EVT_FRAMES_EACH;
    return t[7:0];
  endfunction : event_cap
endpackage : tbnsc_pkg

// File: rtl/tbnsc_mode.sv
// Start-up controller mode resolver
module tbnsc_mode (
  input wire logic local_mon,
  input wire tbnsc_pkg::tbnsc_attach_t attach,
  input wire logic other_sw,
  input wire logic console_present,
  input wire tbnsc_pkg::tbnsc_mode_t console_mode,
  output tbnsc_pkg::tbnsc_mode_t mode,
  output logic forbidden
);
  always_comb begin
    forbidden = 1'b0;
    if (console_present) begin
      mode = console_mode;
    end else begin
      unique case (attach)
        tbnsc_pkg::ATT_NONE: begin
          mode = local_mon ? tbnsc_pkg::MODE_MONITOR : tbnsc_pkg::MODE_RUN;
        end
        tbnsc_pkg::ATT_HOST_CPU: begin
          if (local_mon) begin
            mode = tbnsc_pkg::MODE_MONITOR;
            forbidden = other_sw;
          end else begin
            mode = other_sw ? tbnsc_pkg::MODE_RUN : tbnsc_pkg::MODE_PROGRAM;
          end
        end
        tbnsc_pkg::ATT_LINK_UNIT: begin
          mode = (other_sw || local_mon) ? tbnsc_pkg::MODE_MONITOR
                                         : tbnsc_pkg::MODE_RUN;
        end
        tbnsc_pkg::ATT_PERIPH: begin
          mode = local_mon ? tbnsc_pkg::MODE_MONITOR
                           : tbnsc_pkg::MODE_PROGRAM;
        end
      endcase
    end
  end
endmodule : tbnsc_mode

// File: rtl/tbnsc_nvm.sv
// Nonvolatile parameter store with a torn-write marker
module tbnsc_nvm #(
  parameter int WR_CYCLES = tbnsc_pkg::NVM_WR_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wr_start,
  input wire logic [31:0] wr_word,
  output logic busy,
  output logic [31:0] stored_word,
  output logic stored_ok,
  output logic torn
);
  logic [31:0] nv_word_ff;
  logic [3:0] nv_tag_ff;
  logic nv_dirty_ff;
  logic [31:0] wr_buf_ff;
  logic [15:0] wr_cnt_ff;

  assign busy = wr_cnt_ff != 16'h0000;
  assign stored_word = nv_word_ff;
  assign stored_ok = nv_tag_ff == tbnsc_pkg::NVM_TAG && !nv_dirty_ff;
  assign torn = nv_dirty_ff;

  // Write timer is volatile; a reset mid-write leaves the dirty mark
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_cnt_ff <= 16'h0000;
      wr_buf_ff <= 32'h00000000;
    end else if (clk_en) begin
      if (wr_start && !busy) begin
        wr_cnt_ff <= 16'(WR_CYCLES);
        wr_buf_ff <= wr_word;
      end else if (busy) begin
        wr_cnt_ff <= wr_cnt_ff - 16'h0001;
      end
    end
  end

  // Cells have no reset: they must survive power cycles and unit reset
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_start && !busy) begin
        nv_dirty_ff <= 1'b1;
      end else if (wr_cnt_ff == 16'h0001) begin
        nv_word_ff <= wr_buf_ff;
        nv_tag_ff <= tbnsc_pkg::NVM_TAG;
        nv_dirty_ff <= 1'b0;
      end
    end
  end
endmodule : tbnsc_nvm

// File: rtl/tbnsc_top.sv
// Token-bus node start-up configuration, parameter store and polling
// What this block does
// - No attached unit: local bit 5 on gives MONITOR, off gives RUN.
// - An attached programming console's mode overrides everything else.
// - CPU host link: bit 8 picks RUN/PROGRAM; bit 5 plus 8 forbidden.
// - Other link unit: its switch on or local bit 5 gives MONITOR.
// - Only peripherals: bit 5 on gives MONITOR, off gives PROGRAM.
// - One role switch bit: on means polled unit, off polling unit.
// - After each reset a good join shows in-network, no errors lit.
// - Accepted parameter writes go to nonvolatile store automatically.
// - Cycle time default automatic, 5-255; frames default 10, 5-255.
// - Max node default 62, 2-62; polled per cycle default 4, 1-62.
// - Cycle timer fixes cycle length, runs only while link operates.
// - Nodes above the maximum node number are never polled.
// - Each polling cycle polls exactly the configured node count.
// - Frame budget caps events per cycle: 10 give 4, 3 per extra.
// - Parameter updates are refused while the data link runs.
// - Differing new parameters set the conflict flag word.
// - Init switch reloads parameters at reset, else stored kept.
// - Reset during a parameter write may report a memory error.
// - Node number outside 1 to 62 lights the communication error.
// - Communication and memory errors are node-word bits 14 and 15.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
module tbnsc_top #(
  parameter int CYCLE_TICKS = tbnsc_pkg::CYCLE_UNIT_TICKS,
  parameter int NVM_CYCLES = tbnsc_pkg::NVM_WR_CYCLES,
  parameter bit BANK2_VARIANT = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] sw_bank1,
  input wire logic [7:0] sw_bank2,
  input wire logic [6:0] node_sw,
  input wire logic [1:0] attach_kind,
  input wire logic other_unit_sw,
  input wire logic console_present,
  input wire logic [1:0] console_mode,
  input wire logic net_joined,
  input wire logic token_done,
  input wire logic event_req,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output tbnsc_pkg::tbnsc_mode_t startup_mode,
  output logic polled_role,
  output logic in_network_indicator,
  output logic comm_error_indicator,
  output logic host_error_indicator,
  output logic link_run,
  output logic poll_valid,
  output logic [5:0] poll_node,
  output logic event_grant,
  output logic event_deny
);
  localparam int PIN_W = 29;

  ////////////////////////////////////////
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  tbnsc_pkg::tbnsc_boot_t boot_ff;
  logic [1:0] boot_cnt_ff;
  tbnsc_pkg::tbnsc_mode_t mode_ff;
  tbnsc_pkg::tbnsc_mode_t res_mode;
  logic res_forbidden;
  logic forbidden_ff;
  logic polled_ff;
  logic init_sw_ff;
  logic [6:0] node_ff;
  logic comm_err_ff;
  logic nvm_err_ff;
  logic [31:0] params_ff;
  logic conflict_ff;
  logic link_run_ff;
  logic nvm_busy;
  logic [31:0] nvm_word;
  logic nvm_ok;
  logic nvm_torn;
  logic nvm_wr;
  logic [31:0] nvm_wr_word;
  logic [7:0] s_sw1;
  logic [7:0] s_sw2;
  logic [6:0] s_node;
  logic [1:0] s_attach;
  logic s_other;
  logic s_console;
  logic [1:0] s_cmode;

  assign {s_sw1, s_sw2, s_node, s_attach, s_other, s_console, s_cmode} =
    pin_sync_ff;

  // Switches and attach pins come from another domain
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else if (clk_en) begin
      pin_meta_ff <= {sw_bank1, sw_bank2, node_sw, attach_kind,
                      other_unit_sw, console_present, console_mode};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  tbnsc_mode u_mode (
    .local_mon(s_sw1[tbnsc_pkg::SW1_STARTUP_MON]),
    .attach(tbnsc_pkg::tbnsc_attach_t'(s_attach)),
    .other_sw(s_other),
    .console_present(s_console),
    .console_mode(tbnsc_pkg::tbnsc_mode_t'(s_cmode)),
    .mode(res_mode),
    .forbidden(res_forbidden)
  );

  tbnsc_nvm #(
    .WR_CYCLES(NVM_CYCLES)
  ) u_nvm (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wr_start(nvm_wr),
    .wr_word(nvm_wr_word),
    .busy(nvm_busy),
    .stored_word(nvm_word),
    .stored_ok(nvm_ok),
    .torn(nvm_torn)
  );

  ////////////////////////////////////////
  // Wait out the synchroniser, then latch switches once
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_ff <= tbnsc_pkg::BOOT_SYNC;
      boot_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      unique case (boot_ff)
        tbnsc_pkg::BOOT_SYNC: begin
          boot_cnt_ff <= boot_cnt_ff + 2'h1;
          if (boot_cnt_ff == tbnsc_pkg::SYNC_WAIT) begin
            boot_ff <= tbnsc_pkg::BOOT_LOAD;
          end
        end
        tbnsc_pkg::BOOT_LOAD: boot_ff <= tbnsc_pkg::BOOT_READY;
        tbnsc_pkg::BOOT_READY: boot_ff <= tbnsc_pkg::BOOT_READY;
        default: boot_ff <= tbnsc_pkg::BOOT_SYNC;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= tbnsc_pkg::MODE_PROGRAM;
      forbidden_ff <= 1'b0;
      polled_ff <= 1'b0;
      init_sw_ff <= 1'b0;
      node_ff <= 7'h00;
      comm_err_ff <= 1'b0;
    end else if (clk_en && boot_ff == tbnsc_pkg::BOOT_SYNC &&
                 boot_cnt_ff == tbnsc_pkg::SYNC_WAIT) begin
      mode_ff <= res_mode;
      forbidden_ff <= res_forbidden;
      polled_ff <= BANK2_VARIANT ? s_sw2[tbnsc_pkg::SW2_POLLED]
                                 : s_sw1[tbnsc_pkg::SW1_POLLED];
      init_sw_ff <= BANK2_VARIANT ? s_sw2[tbnsc_pkg::SW2_PARAM_INIT]
                                  : s_sw1[tbnsc_pkg::SW1_PARAM_INIT];
      node_ff <= s_node;
      comm_err_ff <= s_node < tbnsc_pkg::NODE_MIN ||
                     s_node > tbnsc_pkg::NODE_MAX;
    end
  end

  ////////////////////////////////////////
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_addr;
  logic param_wr;
  logic param_take;
  logic conflict_clr;
  logic [31:0] new_params;

  // Address and data are taken together, one write at a time
  assign s_axi_awready = clk_en && s_axi_awvalid && s_axi_wvalid &&
                         !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arready && s_axi_arvalid;
  assign wr_addr = {s_axi_awaddr[7:2], 2'h0};
  assign new_params = s_axi_wdata & tbnsc_pkg::PARAM_MASK;
  assign param_wr = wr_fire && wr_addr == tbnsc_pkg::REG_PARAM;
  assign param_take = param_wr && boot_ff == tbnsc_pkg::BOOT_READY &&
                      !link_run_ff && !nvm_busy && s_axi_wstrb == 4'hF &&
                      tbnsc_pkg::param_ok(new_params);
  assign conflict_clr = wr_fire && wr_addr == tbnsc_pkg::REG_CONFLICT &&
                        s_axi_wstrb[0] &&
                        s_axi_wdata[tbnsc_pkg::CONFLICT_BIT];

  assign nvm_wr = param_take ||
                  (boot_ff == tbnsc_pkg::BOOT_LOAD && init_sw_ff);
  assign nvm_wr_word = param_take ? new_params : tbnsc_pkg::PARAM_DEF;

  // Parameters in force
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      params_ff <= tbnsc_pkg::PARAM_DEF;
      nvm_err_ff <= 1'b0;
    end else if (clk_en) begin
      if (boot_ff == tbnsc_pkg::BOOT_LOAD) begin
        if (init_sw_ff || !nvm_ok) begin
          params_ff <= tbnsc_pkg::PARAM_DEF;
        end else begin
          params_ff <= nvm_word & tbnsc_pkg::PARAM_MASK;
        end
        if (nvm_torn) begin
          nvm_err_ff <= 1'b1;
        end
      end else if (param_take) begin
        params_ff <= new_params;
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conflict_ff <= 1'b0;
    end else if (clk_en) begin
      if (param_take && new_params != params_ff) begin
        conflict_ff <= 1'b1;
      end else if (conflict_clr) begin
        conflict_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_run_ff <= 1'b0;
    end else if (clk_en && wr_fire && wr_addr == tbnsc_pkg::REG_CTRL &&
                 s_axi_wstrb[0]) begin
      link_run_ff <= s_axi_wdata[tbnsc_pkg::CTRL_LINK_RUN] &&
                     boot_ff == tbnsc_pkg::BOOT_READY;
    end
  end

  ////////////////////////////////////////
  logic [7:0] cyc_len;
  logic [7:0] frames;
  logic [5:0] max_node;
  logic [5:0] polled_cnt;
  logic [31:0] tick_cnt_ff;
  logic [7:0] unit_cnt_ff;
  logic tick_wrap;
  logic cycle_end;
  logic [5:0] poll_left_ff;
  logic [5:0] poll_ptr_ff;
  logic [7:0] evt_cnt_ff;

  assign cyc_len = params_ff[tbnsc_pkg::CYC_LSB +: 8];
  assign frames = params_ff[tbnsc_pkg::FRM_LSB +: 8];
  assign max_node = params_ff[tbnsc_pkg::MAXN_LSB +: 6];
  assign polled_cnt = params_ff[tbnsc_pkg::POLL_LSB +: 6];
  assign tick_wrap = tick_cnt_ff == 32'(CYCLE_TICKS - 1);
  // Automatic length follows token return instead of the timer
  assign cycle_end = link_run_ff &&
                     (cyc_len == tbnsc_pkg::CYC_AUTO ? token_done :
                      tick_wrap && unit_cnt_ff == cyc_len - 8'h01);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_ff <= 32'h00000000;
      unit_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (!link_run_ff || cycle_end) begin
        tick_cnt_ff <= 32'h00000000;
        unit_cnt_ff <= 8'h00;
      end else if (tick_wrap) begin
        tick_cnt_ff <= 32'h00000000;
        unit_cnt_ff <= unit_cnt_ff + 8'h01;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      end
    end
  end

  // Polling burst at the end of each cycle, polling role only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      poll_left_ff <= 6'h00;
      poll_ptr_ff <= tbnsc_pkg::NODE_FIRST;
      poll_valid <= 1'b0;
      poll_node <= 6'h00;
    end else if (clk_en) begin
      poll_valid <= 1'b0;
      if (!link_run_ff || polled_ff) begin
        poll_left_ff <= 6'h00;
      end else if (cycle_end) begin
        poll_left_ff <= polled_cnt;
      end else if (poll_left_ff != 6'h00) begin
        poll_left_ff <= poll_left_ff - 6'h01;
        poll_valid <= 1'b1;
        if (poll_ptr_ff > max_node) begin
          poll_node <= tbnsc_pkg::NODE_FIRST;
          poll_ptr_ff <= tbnsc_pkg::NODE_FIRST + 6'h01;
        end else begin
          poll_node <= poll_ptr_ff;
          poll_ptr_ff <= poll_ptr_ff >= max_node ? tbnsc_pkg::NODE_FIRST
                                                  : poll_ptr_ff + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_cnt_ff <= 8'h00;
      event_grant <= 1'b0;
      event_deny <= 1'b0;
    end else if (clk_en) begin
      event_grant <= 1'b0;
      event_deny <= 1'b0;
      if (cycle_end || !link_run_ff) begin
        evt_cnt_ff <= 8'h00;
      end
      if (event_req) begin
        if (!link_run_ff || evt_cnt_ff < tbnsc_pkg::event_cap(frames)) begin
          event_grant <= 1'b1;
          if (link_run_ff && !cycle_end) begin
            evt_cnt_ff <= evt_cnt_ff + 8'h01;
          end
        end else begin
          event_deny <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////
  logic [31:0] rd_mux;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;

  always_comb begin
    rd_resp = tbnsc_pkg::RESP_OKAY;
    rd_mux = 32'h00000000;
    unique case ({s_axi_araddr[7:2], 2'h0})
      tbnsc_pkg::REG_CTRL: rd_mux[tbnsc_pkg::CTRL_LINK_RUN] = link_run_ff;
      tbnsc_pkg::REG_STATUS: rd_mux = {9'h000, node_ff, 5'h00, nvm_err_ff,
        forbidden_ff, nvm_busy, host_error_indicator, comm_err_ff,
        in_network_indicator, link_run_ff,
        boot_ff == tbnsc_pkg::BOOT_READY, polled_ff, mode_ff};
      tbnsc_pkg::REG_PARAM: rd_mux = params_ff;
      tbnsc_pkg::REG_NODE_WORD: begin
        rd_mux[tbnsc_pkg::NW_COMM_ERR] = comm_err_ff;
        rd_mux[tbnsc_pkg::NW_NVM_ERR] = nvm_err_ff;
      end
      tbnsc_pkg::REG_CONFLICT: rd_mux[tbnsc_pkg::CONFLICT_BIT] = conflict_ff;
      tbnsc_pkg::REG_POLL: rd_mux = {8'h00, evt_cnt_ff,
                                     tbnsc_pkg::event_cap(frames),
                                     2'h0, poll_ptr_ff};
      default: rd_resp = tbnsc_pkg::RESP_DECERR;
    endcase
  end

  always_comb begin
    unique case (wr_addr)
      tbnsc_pkg::REG_CTRL, tbnsc_pkg::REG_CONFLICT: begin
        wr_resp = tbnsc_pkg::RESP_OKAY;
      end
      tbnsc_pkg::REG_PARAM: begin
        wr_resp = param_take ? tbnsc_pkg::RESP_OKAY : tbnsc_pkg::RESP_SLVERR;
      end
      tbnsc_pkg::REG_STATUS, tbnsc_pkg::REG_NODE_WORD,
      tbnsc_pkg::REG_POLL: wr_resp = tbnsc_pkg::RESP_SLVERR;
      default: wr_resp = tbnsc_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tbnsc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tbnsc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////
  assign startup_mode = mode_ff;
  assign polled_role = polled_ff;
  assign link_run = link_run_ff;
  assign in_network_indicator = boot_ff == tbnsc_pkg::BOOT_READY &&
                                !comm_err_ff && net_joined;
  assign comm_error_indicator = comm_err_ff;
  assign host_error_indicator = nvm_err_ff || forbidden_ff;
endmodule : tbnsc_top

// File: test/tbnsc_chk.sv
// Port checker for the start-up configuration block
module tbnsc_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic event_req,
  input wire logic event_grant,
  input wire logic event_deny,
  input wire logic link_run,
  input wire logic poll_valid,
  input wire logic [5:0] poll_node,
  input wire logic polled_role,
  input wire logic comm_error_indicator,
  input wire logic in_network_indicator,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_evt_answer: assert property (
    event_req && clk_en |=> event_grant != event_deny) else $error("no answer");
  a_evt_free: assert property (
    event_req && clk_en && !link_run |=> event_grant) else $error("refused");
  a_grant_cause: assert property (
    event_grant |-> $past(event_req)) else $error("stray grant");
  a_poll_range: assert property (
    poll_valid |-> poll_node != 6'h00 && poll_node <= 6'h3E) else $error("node");
  a_poll_role: assert property (
    poll_valid |-> !polled_role) else $error("polled unit polls");
  a_poll_link: assert property (
    poll_valid |-> $past(link_run)) else $error("poll while halted");
  a_comm_err: assert property (
    comm_error_indicator |-> !in_network_indicator) else $error("bad node");
  a_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response dropped");
  c_deny: cover property (event_deny);
  c_poll: cover property (poll_valid);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : tbnsc_chk

bind tbnsc_top tbnsc_chk u_chk (.*);

// File: test/tbnsc_peer.sv
// Far-side model: ring join, token returns, event bursts
module tbnsc_peer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ev_go,
  output logic net_joined,
  output logic token_done,
  output logic event_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] tick_ff;
  logic [2:0] burst_ff;
  logic arm_ff;
  ////////////////////////////////////////
  // ring join and token return every 32 clocks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_ff <= 5'h00;
      token_done <= 1'b0;
      net_joined <= 1'b0;
    end else begin
      tick_ff <= tick_ff + 5'h01;
      token_done <= (tick_ff == 5'h1F);
      net_joined <= 1'b1;
    end
  end
  // Burst starts after a token return so it fits in one cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_ff <= 1'b0;
      burst_ff <= 3'h0;
    end else if (arm_ff && token_done) begin
      arm_ff <= 1'b0;
      burst_ff <= 3'h6;
    end else begin
      arm_ff <= arm_ff | ev_go;
      burst_ff <= burst_ff - {2'h0, burst_ff != 3'h0};
    end
  end
  assign event_req = (burst_ff != 3'h0);
endmodule : tbnsc_peer

// File: test/tbnsc_top_tb.sv
// Self-checking bench for the start-up configuration block
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tbnsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, ev_go = 1'b0;
  logic other_unit_sw = 1'b0, console_present = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [7:0] sw_bank1 = 8'h00, sw_bank2 = 8'h00;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [6:0] node_sw = 7'h05;
  logic [1:0] attach_kind = 2'h0, console_mode = 2'h0, s_axi_bresp;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_arready, s_axi_rvalid, net_joined, token_done, event_req;
  logic [1:0] s_axi_rresp, r;
  tbnsc_pkg::tbnsc_mode_t startup_mode;
  logic polled_role, in_network_indicator, comm_error_indicator;
  logic host_error_indicator, link_run, poll_valid, event_grant, event_deny;
  logic [5:0] poll_node;
  int bad_count = 0, num_checks = 0, grants = 0;
  always #5 core_clk = ~core_clk;
  tbnsc_top #(.CYCLE_TICKS(4), .NVM_CYCLES(3)) u_dut (.*);
  tbnsc_peer u_peer (.*);
  always @(posedge core_clk) if (event_grant === 1'b1) grants++;
  ////////////////////////////////////////
  task automatic boot(input logic [7:0] b1, logic [1:0] ak, logic osw,
                      logic [6:0] n);
    sys_rst <= 1'b1;
    sw_bank1 <= b1;
    attach_kind <= ak;
    other_unit_sw <= osw;
    node_sw <= n;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask : boot
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
  initial begin
    boot(8'h50, 2'h0, 1'b0, 7'h05);
    `CHK("mode", tbnsc_pkg::MODE_MONITOR, startup_mode)
    `CHK("role", 1'b0, polled_role)
    `CHK("in_net", 1'b1, in_network_indicator)
    `CHK("errs", 2'h0, {comm_error_indicator, host_error_indicator})
    rd(tbnsc_pkg::REG_PARAM);
    `CHK("defaults", 32'h043E0A00, d)
    wr(tbnsc_pkg::REG_PARAM, 32'h043E0400);
    `CHK("range", 2'h2, r)
    wr(tbnsc_pkg::REG_PARAM, 32'h023E0D00);
    repeat (5) @(posedge core_clk);
    rd(tbnsc_pkg::REG_CONFLICT);
    `CHK("conflict", 1'b1, d[0])
    rd(8'h20);
    `CHK("unmapped", 2'h3, r)
    wr(tbnsc_pkg::REG_CTRL, 32'h1);
    wr(tbnsc_pkg::REG_PARAM, 32'h043E0A00);
    `CHK("running", 2'h2, r)
    $display("register tests done");
    grants = 0;
    ev_go <= 1'b1;
    @(posedge core_clk);
    ev_go <= 1'b0;
    repeat (60) @(posedge core_clk);
    `CHK("grants", 5, grants)
    $display("event test done");
    console_present <= 1'b1;
    boot(8'h80, 2'h2, 1'b1, 7'h05);
    `CHK("console", tbnsc_pkg::MODE_PROGRAM, startup_mode)
    `CHK("polled", 1'b1, polled_role)
    console_present <= 1'b0;
    boot(8'h00, 2'h1, 1'b1, 7'h05);
    `CHK("cpu_host", tbnsc_pkg::MODE_RUN, startup_mode)
    rd(tbnsc_pkg::REG_PARAM);
    `CHK("kept", 32'h023E0D00, d)
    boot(8'h00, 2'h2, 1'b1, 7'h05);
    `CHK("link_unit", tbnsc_pkg::MODE_MONITOR, startup_mode)
    boot(8'h10, 2'h3, 1'b0, 7'h00);
    `CHK("periph", tbnsc_pkg::MODE_MONITOR, startup_mode)
    `CHK("comm_err", 1'b1, comm_error_indicator)
    rd(tbnsc_pkg::REG_NODE_WORD);
    `CHK("node_word", 1'b1, d[14])
    $display("start-up tests done");
    close_out();
  end
endmodule : tbnsc_top_tb
